// >>> logic/hvd_ctrl.sv
// Control, update and thermal logic of the high-voltage DAC
`timescale 1ns/1ps
`default_nettype none
`include "hvd_defines.svh"
module hvd_ctrl (
  input  wire logic           clk,             // 200 MHz block clock
  input  wire logic           srst,            // Synchronous reset, active high
  input  wire logic           wr_stb,          // Decoded frame write strobe
  input  wire hvd_pkg::hvd_wr_t wr,            // Address and data of the write
  input  wire logic [2:0]     rd_addr,         // Readback address
  input  wire logic           rd_stb,          // Readback strobe
  output var  logic [11:0]    rd_data,         // Readback data, one cycle later
  input  wire logic           load_strobe_n,   // Load pin, async
  input  wire logic           async_clear_n,   // Clear pin, async
  input  wire logic           range_sel,       // Range pin, async, high selects 30 V
  input  wire logic           over_temp,       // Die sensor above trip point, async
  output var  logic           alarm_n,         // Alarm pin, low while tripped
  output var  hvd_pkg::hvd_out_t analog_ctl    // Drive to the analog section
);
  logic       ld_s;
  logic       clr_s;
  logic       rng_s;
  logic       hot_s;
  logic       ld_d_r;
  logic       clr_d_r;
  logic [6:0]  ctrl_r;
  logic [11:0] input_r;
  logic [11:0] dac_r;
  logic        range_r;
  logic        ld_fall;
  logic        clr_fall;
  logic        wr_input;
  logic        wr_ctrl;
  logic        load_now;

  hvd_sync u_ld  (.clk(clk), .srst(srst), .rst_v(1'b1), .d(load_strobe_n), .q(ld_s));
  hvd_sync u_clr (.clk(clk), .srst(srst), .rst_v(1'b1), .d(async_clear_n), .q(clr_s));
  hvd_sync u_rng (.clk(clk), .srst(srst), .rst_v(1'b0), .d(range_sel),     .q(rng_s));
  hvd_sync u_hot (.clk(clk), .srst(srst), .rst_v(1'b0), .d(over_temp),     .q(hot_s));

  always_ff @(posedge clk) begin
    if (srst) begin
      ld_d_r  <= 1'b1;
      clr_d_r <= 1'b1;
    end else begin
      ld_d_r  <= ld_s;
      clr_d_r <= clr_s;
    end
  end

  assign clr_fall = clr_d_r & ~clr_s;
  assign ld_fall  = ld_d_r & ~ld_s;
  assign wr_input = wr_stb && (wr.addr == `HVD_ADDR_INPUT);
  assign wr_ctrl  = wr_stb && (wr.addr == `HVD_ADDR_CTRL);
  // synchronous update when load held low
  assign load_now = ld_fall | (wr_input & ~ld_s);

  always_ff @(posedge clk) begin
    if (srst) begin
      input_r <= `HVD_CODE_RESET;
    end else if (clr_fall) begin
      input_r <= `HVD_CODE_RESET;
    end else if (wr_input) begin
      input_r <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dac_r <= `HVD_CODE_RESET;
    end else if (clr_fall) begin
      dac_r <= `HVD_CODE_RESET;
    end else if (load_now) begin
      dac_r <= wr_input ? wr.data : input_r;
    end
  end

  // range latched on each DAC load
  always_ff @(posedge clk) begin
    if (srst) begin
      range_r <= 1'b0;
    end else if (load_now || clr_fall) begin
      range_r <= rng_s;
    end
  end

  // control register; trip set beats clear
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= `HVD_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r[`HVD_BIT_PWR]   <= wr.data[`HVD_BIT_PWR];
        ctrl_r[`HVD_BIT_CLAMP] <= wr.data[`HVD_BIT_CLAMP];
      end
      if (hot_s) begin
        ctrl_r[`HVD_BIT_THERM] <= 1'b1;
      end else if (wr_ctrl && !wr.data[`HVD_BIT_THERM]) begin
        ctrl_r[`HVD_BIT_THERM] <= 1'b0;
      end
    end
  end

  // readback of control and input registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 12'h000;
    end else if (rd_stb) begin
      unique case (rd_addr)
        `HVD_ADDR_CTRL:  rd_data <= {5'h00, ctrl_r};
        `HVD_ADDR_INPUT: rd_data <= input_r;
        default:         rd_data <= 12'h000;
      endcase
    end else begin
      rd_data <= 12'h000;
    end
  end

  // analog drive; digital path never gated
  always_ff @(posedge clk) begin
    if (srst) begin
      analog_ctl <= '{powered: 1'b0, clamp_gnd: 1'b0, tristate: 1'b1, range_30v: 1'b0, code: 12'h000};
      alarm_n    <= 1'b1;
    end else begin
      analog_ctl.powered   <= ctrl_r[`HVD_BIT_PWR] & ~ctrl_r[`HVD_BIT_THERM];
      analog_ctl.tristate  <= ctrl_r[`HVD_BIT_THERM] |
                              (~ctrl_r[`HVD_BIT_PWR] & ctrl_r[`HVD_BIT_CLAMP]);
      analog_ctl.clamp_gnd <= ~ctrl_r[`HVD_BIT_THERM] & ~ctrl_r[`HVD_BIT_PWR] & ~ctrl_r[`HVD_BIT_CLAMP];
      analog_ctl.range_30v <= range_r;
      analog_ctl.code      <= dac_r;
      alarm_n              <= ~ctrl_r[`HVD_BIT_THERM];
    end
  end

  property p_ctrl_reset;
    @(posedge clk) srst |=> (ctrl_r == `HVD_CTRL_RESET);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value wrong");

  property p_code_reset;
    @(posedge clk) srst |=> (input_r == 12'h000 && dac_r == 12'h000);
  endproperty
  a_code_reset: assert property (p_code_reset) else $error("code registers not cleared");

  property p_clear;
    @(posedge clk) disable iff (srst) clr_fall |=> (dac_r == 12'h000 && input_r == 12'h000);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero registers");

  property p_load;
    @(posedge clk) disable iff (srst) (ld_fall && !clr_fall && !wr_input) |=> (dac_r == $past(input_r));
  endproperty
  a_load: assert property (p_load) else $error("load did not copy input");

  property p_sync_upd;
    @(posedge clk) disable iff (srst) (wr_input && !ld_s && !clr_fall) |=> (dac_r == $past(wr.data));
  endproperty
  a_sync_upd: assert property (p_sync_upd) else $error("synchronous update missed");

  property p_hold;
    @(posedge clk) disable iff (srst) (!load_now && !clr_fall) |=> $stable(dac_r) && $stable(range_r);
  endproperty
  a_hold: assert property (p_hold) else $error("DAC or range changed without load");

  property p_trip;
    @(posedge clk) disable iff (srst) hot_s |=> ctrl_r[0] ##1 !alarm_n;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not flagged");

  property p_latch;
    @(posedge clk) disable iff (srst) (ctrl_r[0] && !(wr_ctrl && !wr.data[0])) |=> ctrl_r[0];
  endproperty
  a_latch: assert property (p_latch) else $error("trip flag dropped early");

  property p_shut;
    @(posedge clk) disable iff (srst) ctrl_r[0] |=> (!analog_ctl.powered && analog_ctl.tristate);
  endproperty
  a_shut: assert property (p_shut) else $error("analog not shut down");

  property p_pwr_wr;
    @(posedge clk) disable iff (srst) wr_ctrl |=> (ctrl_r[`HVD_BIT_PWR] == $past(wr.data[`HVD_BIT_PWR]));
  endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("power bit not written");

  property p_powered;
    @(posedge clk) disable iff (srst) (ctrl_r[`HVD_BIT_PWR] && !ctrl_r[`HVD_BIT_THERM]) |=>
      (analog_ctl.powered && !analog_ctl.tristate && !analog_ctl.clamp_gnd);
  endproperty
  a_powered: assert property (p_powered) else $error("channel not powered up");

  property p_clamp_wr;
    @(posedge clk) disable iff (srst) wr_ctrl |=> (ctrl_r[`HVD_BIT_CLAMP] == $past(wr.data[`HVD_BIT_CLAMP]));
  endproperty
  a_clamp_wr: assert property (p_clamp_wr) else $error("clamp bit not written");

  property p_resv;
    @(posedge clk) disable iff (srst) ((ctrl_r & ~(`HVD_CTRL_WMASK | 7'h01)) == 7'h00);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved control bit set");

  property p_ctrl_keep;
    @(posedge clk) disable iff (srst) !wr_ctrl |=> $stable(ctrl_r[`HVD_BIT_CLAMP:1]);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control bits changed without write");

  property p_down_tri;
    @(posedge clk) disable iff (srst) (!ctrl_r[`HVD_BIT_PWR] && ctrl_r[`HVD_BIT_CLAMP]) |=>
      (analog_ctl.tristate && !analog_ctl.clamp_gnd && !analog_ctl.powered);
  endproperty
  a_down_tri: assert property (p_down_tri) else $error("powered-down output not tristate");

  property p_down_gnd;
    @(posedge clk) disable iff (srst)
      (!ctrl_r[`HVD_BIT_PWR] && !ctrl_r[`HVD_BIT_CLAMP] && !ctrl_r[`HVD_BIT_THERM]) |=>
      (analog_ctl.clamp_gnd && !analog_ctl.tristate && !analog_ctl.powered);
  endproperty
  a_down_gnd: assert property (p_down_gnd) else $error("powered-down output not grounded");

  property p_code_out;
    @(posedge clk) disable iff (srst) 1'b1 |=> (analog_ctl.code == $past(dac_r));
  endproperty
  a_code_out: assert property (p_code_out) else $error("output code differs from DAC register");

  property p_range_out;
    @(posedge clk) disable iff (srst) 1'b1 |=> (analog_ctl.range_30v == $past(range_r));
  endproperty
  a_range_out: assert property (p_range_out) else $error("output range differs from latch");

  property p_range_take;
    @(posedge clk) disable iff (srst) (load_now || clr_fall) |=> (range_r == $past(rng_s));
  endproperty
  a_range_take: assert property (p_range_take) else $error("range not taken at load");

  property p_input_wr;
    @(posedge clk) disable iff (srst) (wr_input && !clr_fall) |=> (input_r == $past(wr.data));
  endproperty
  a_input_wr: assert property (p_input_wr) else $error("input register write lost");

  property p_input_keep;
    @(posedge clk) disable iff (srst) (!wr_input && !clr_fall) |=> $stable(input_r);
  endproperty
  a_input_keep: assert property (p_input_keep) else $error("input register changed without write");

  property p_down_wr;
    @(posedge clk) disable iff (srst) (wr_input && !ld_s && !clr_fall && !ctrl_r[`HVD_BIT_PWR]) |=>
      (dac_r == $past(wr.data));
  endproperty
  a_down_wr: assert property (p_down_wr) else $error("update refused while powered down");

  property p_nop;
    @(posedge clk) disable iff (srst) (wr_stb && !wr_input && !wr_ctrl && !clr_fall) |=>
      ($stable(input_r) && $stable(ctrl_r[`HVD_BIT_CLAMP:1]));
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation write changed a register");

  property p_rd_ctrl;
    @(posedge clk) disable iff (srst) (rd_stb && rd_addr == `HVD_ADDR_CTRL) |=>
      (rd_data == {5'h00, $past(ctrl_r)});
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");

  property p_rd_input;
    @(posedge clk) disable iff (srst) (rd_stb && rd_addr == `HVD_ADDR_INPUT && !ctrl_r[`HVD_BIT_PWR]) |=>
      (rd_data == $past(input_r));
  endproperty
  a_rd_input: assert property (p_rd_input) else $error("readback lost while powered down");

  property p_rd_trip;
    @(posedge clk) disable iff (srst) (rd_stb && rd_addr == `HVD_ADDR_CTRL && ctrl_r[`HVD_BIT_THERM]) |=>
      (rd_data[`HVD_BIT_THERM] && rd_data[11:7] == 5'h00);
  endproperty
  a_rd_trip: assert property (p_rd_trip) else $error("readback wrong in shutdown");

  property p_rd_other;
    @(posedge clk) disable iff (srst) (rd_stb && rd_addr != `HVD_ADDR_CTRL && rd_addr != `HVD_ADDR_INPUT) |=>
      (rd_data == 12'h000);
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("unmapped readback not zero");

  property p_rd_idle;
    @(posedge clk) disable iff (srst) !rd_stb |=> (rd_data == 12'h000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  property p_clr_win;
    @(posedge clk) disable iff (srst) (clr_fall && ld_fall) |=>
      (dac_r == `HVD_CODE_RESET && input_r == `HVD_CODE_RESET);
  endproperty
  a_clr_win: assert property (p_clr_win) else $error("load won over clear");

  property p_alarm;
    @(posedge clk) disable iff (srst) 1'b1 |=> (alarm_n == !$past(ctrl_r[`HVD_BIT_THERM]));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm differs from flag");

  property p_flag_clr;
    @(posedge clk) disable iff (srst) (wr_ctrl && !wr.data[`HVD_BIT_THERM] && !hot_s) |=> !ctrl_r[`HVD_BIT_THERM];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by write");

  property p_srst_out;
    @(posedge clk) srst |=>
      (analog_ctl.tristate && !analog_ctl.powered && !analog_ctl.clamp_gnd && alarm_n);
  endproperty
  a_srst_out: assert property (p_srst_out) else $error("outputs wrong after reset");

  property p_pwr_keep;
    @(posedge clk) disable iff (srst) (wr_ctrl && !ld_fall && !clr_fall) |=> $stable(dac_r);
  endproperty
  a_pwr_keep: assert property (p_pwr_keep) else $error("control write changed DAC register");
endmodule : hvd_ctrl
`default_nettype wire

// >>> logic/hvd_defines.svh
// Offsets, field positions, reset values, range voltages and code span of the DAC control block
`ifndef HVD_DEFINES_SVH
`define HVD_DEFINES_SVH
`define HVD_ADDR_NOP        3'h0
`define HVD_ADDR_INPUT      3'h1
`define HVD_ADDR_CTRL       3'h7
`define HVD_CTRL_RESET      7'h40
`define HVD_CODE_RESET      12'h000
`define HVD_BIT_THERM       0
`define HVD_BIT_PWR         2
`define HVD_BIT_CLAMP       6
`define HVD_CTRL_WMASK      7'h44
`define HVD_RANGE_LO_V      30
`define HVD_RANGE_HI_V      60
`define HVD_CODE_SPAN       4096
`endif

// >>> logic/hvd_pkg.sv
// Types shared by the DAC control block
package hvd_pkg;
  typedef struct packed {
    logic [2:0]  addr;
    logic [11:0] data;
  } hvd_wr_t;
  typedef struct packed {
    logic        powered;
    logic        clamp_gnd;
    logic        tristate;
    logic        range_30v;
    logic [11:0] code;
  } hvd_out_t;
endpackage : hvd_pkg

// >>> logic/hvd_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module hvd_sync (
  input  wire logic clk,   // Block clock
  input  wire logic srst,  // Synchronous reset
  input  wire logic rst_v, // Value taken at reset
  input  wire logic d,     // Asynchronous input
  output var  logic q      // Synchronised output
);
  logic meta_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= rst_v;
      q      <= rst_v;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : hvd_sync
`default_nettype wire

// >>> tb/hvd_host.sv
// Host-side model: decoded register writes and load pin
`timescale 1ns/1ps
`default_nettype none
module hvd_host (
  input  wire logic             clk,          // Block clock
  output var  logic             wr_stb,       // Write strobe
  output var  hvd_pkg::hvd_wr_t wr,           // Write address and data
  output var  logic             load_strobe_n // Load pin
);
  initial begin
    wr_stb = 1'b0;
    wr = '0;
    load_strobe_n = 1'b1;
  end
  task automatic write(input logic [2:0] a, input logic [11:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    wr <= '{addr: a, data: d};
    @(posedge clk);
    wr_stb <= 1'b0;
    wr <= ~wr;
  endtask : write
  task automatic set_load(input logic v);
    @(posedge clk);
    load_strobe_n <= v;
  endtask : set_load
endmodule : hvd_host
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the DAC control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              rd_stb = 1'b0;
  logic              async_clear_n = 1'b1;
  logic              range_sel = 1'b1;
  logic              over_temp = 1'b0;
  logic              wr_stb, load_strobe_n, alarm_n;
  logic [2:0]        rd_addr = 3'h0;
  logic [11:0]       rd_data, v;
  hvd_pkg::hvd_wr_t  wr;
  hvd_pkg::hvd_out_t ac;
  int                miscompares = 0;
  int                num_checks = 0;
  always #2.5 clk = ~clk;
  hvd_host u_host (.clk(clk), .wr_stb(wr_stb), .wr(wr), .load_strobe_n(load_strobe_n));
  hvd_ctrl dut (.clk(clk), .srst(srst), .wr_stb(wr_stb), .wr(wr), .rd_addr(rd_addr), .rd_stb(rd_stb),
    .rd_data(rd_data), .load_strobe_n(load_strobe_n), .async_clear_n(async_clear_n),
    .range_sel(range_sel), .over_temp(over_temp), .alarm_n(alarm_n), .analog_ctl(ac));
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask : chk
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    rd_stb <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    rd_addr <= ~a;
    #1 v = rd_data;
  endtask : rd
  // Pins pass a synchroniser; load and clear also pass an edge detector
  task automatic pins;
    repeat (8) @(posedge clk);
    #1;
  endtask : pins
  task automatic t_reset;
    rd(3'h7);
    chk(v, 12'h040);
    rd(3'h1);
    chk(v, 12'h000);
    chk(ac.code, 12'h000);
    chk(ac.tristate, 12'h001);
    chk(alarm_n, 12'h001);
  endtask : t_reset
  task automatic t_power;
    u_host.write(3'h7, 12'h045);
    rd(3'h7);
    chk(v, 12'h044);
    chk(ac.powered, 12'h001);
    u_host.write(3'h0, 12'hfff);
    rd(3'h7);
    chk(v, 12'h044);
    rd(3'h1);
    chk(v, 12'h000);
    rd(3'h0);
    chk(v, 12'h000);
    u_host.write(3'h7, 12'h000);
    rd(3'h7);
    chk(v, 12'h000);
    chk(ac.powered, 12'h000);
    chk(ac.clamp_gnd, 12'h001);
  endtask : t_power
  task automatic t_load;
    u_host.write(3'h1, 12'habc);
    pins();
    chk(ac.code, 12'h000);
    u_host.set_load(1'b0);
    pins();
    chk(ac.code, 12'habc);
    chk(ac.range_30v, 12'h001);
    @(posedge clk) range_sel <= 1'b0;
    u_host.set_load(1'b1);
    pins();
    chk(ac.range_30v, 12'h001);
    u_host.set_load(1'b0);
    pins();
    u_host.write(3'h1, 12'h123);
    pins();
    chk(ac.code, 12'h123);
    chk(ac.range_30v, 12'h000);
    u_host.set_load(1'b1);
    u_host.write(3'h7, 12'h004);
    pins();
    chk(ac.code, 12'h123);
  endtask : t_load
  task automatic t_clear;
    @(posedge clk) async_clear_n <= 1'b0;
    pins();
    chk(ac.code, 12'h000);
    rd(3'h1);
    chk(v, 12'h000);
    @(posedge clk) async_clear_n <= 1'b1;
    u_host.write(3'h1, 12'h5a5);
    pins();
    // Clear and load fall at the same edge
    fork
      u_host.set_load(1'b0);
      @(posedge clk) async_clear_n <= 1'b0;
    join
    pins();
    chk(ac.code, 12'h000);
    rd(3'h1);
    chk(v, 12'h000);
    @(posedge clk) async_clear_n <= 1'b1;
    u_host.set_load(1'b1);
  endtask : t_clear
  task automatic t_therm;
    @(posedge clk) over_temp <= 1'b1;
    pins();
    rd(3'h7);
    chk(v, 12'h005);
    chk(alarm_n, 12'h000);
    chk(ac.tristate, 12'h001);
    @(posedge clk) over_temp <= 1'b0;
    pins();
    chk(alarm_n, 12'h000);
    u_host.write(3'h7, 12'h004);
    pins();
    chk(alarm_n, 12'h001);
  endtask : t_therm
  task automatic t_rerun;
    u_host.write(3'h1, 12'h7ff);
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(3'h7);
    chk(v, 12'h040);
    chk(ac.tristate, 12'h001);
    rd(3'h1);
    chk(v, 12'h000);
  endtask : t_rerun
  task automatic report_and_stop;
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_power();
    t_load();
    t_clear();
    t_therm();
    t_rerun();
    report_and_stop();
  end
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
